/* File: core/completion_counter.sv */
`timescale 1ns/100ps

// counts completions on selected ports in one cycle
module completion_counter #(
    parameter int NPORTS = 32
) (
    input  wire logic [NPORTS-1:0]       done_in,
    input  wire logic [NPORTS-1:0]       select,
    output logic      [$clog2(NPORTS):0] count
);

    // population count of selected completions
    always_comb begin
        count = '0;
        for (int i = 0; i < NPORTS; i++) begin
            count = count + {{$clog2(NPORTS){1'b0}}, done_in[i] & select[i]};
        end
    end

endmodule

/* File: core/hba_irq_status_coalescing.sv */
// Notes on behaviour
// - pending bit x sets on port x interrupt; software writes one to clear
// - only available-port bits and the coalescing vector bit may ever set
// - availability map is a read-only 32-bit mask of usable ports
// - map must be nonzero with no more bits than port count plus one
// - version word holds major high, minor low; 1.3 reads 0001h/0300h
// - older revisions report 0.95, 1.0, 1.1 and 1.2 codes
// - timeout in ms units, resets to one, zero is reserved
// - countdown loads timeout, decrements only while selected ports are busy
// - countdown at zero raises coalescing interrupt and reloads
// - tally counts selected completions, interrupt at threshold, then clears
// - threshold zero disables count-based coalescing interrupts
// - read-only vector index names unused port; its pending bit sets
// - vector index also selects the message interrupt vector
// - coalescing on bit low means no coalescing interrupts
// - rising coalescing on bit loads the new timeout and threshold
// - port select register chooses ports; change acts within one tick
// - global interrupt on bit, reset low, gates all interrupt delivery
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`include "irq_coalesce_defines.svh"

module hba_irq_status_coalescing #(
    parameter int                        NPORTS      = 32,
    parameter logic [31:0]               PORTS_AVAIL = 32'h0000_000f,
    parameter logic [4:0]                PORT_COUNT  = 5'h1f,
    parameter logic [4:0]                CCC_VECTOR  = 5'h1f,
    parameter irq_coalesce_pkg::spec_rev_t SPEC_REV  = irq_coalesce_pkg::REV_1_3,
    parameter int                        TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [31:0]            reg_rdata,
    input  wire logic [NPORTS-1:0]      port_irq_event,
    input  wire logic [NPORTS-1:0]      port_cmd_busy,
    input  wire logic [NPORTS-1:0]      port_cmd_done,
    output logic                        host_irq,
    output logic                        coalesce_irq_pulse,
    output logic      [4:0]             msi_vector
);
    import irq_coalesce_pkg::*;

    // ==========================================================
    // constant words
    localparam logic [31:0] CCC_BIT = 32'h1 << CCC_VECTOR;
    // defined pending positions: available ports and the coalescing vector
    localparam logic [31:0] DEFINED_MASK = PORTS_AVAIL | CCC_BIT;

    // count of ones in a word
    function automatic int ones(input logic [31:0] w);
        int n;
        n = 0;
        for (int i = 0; i < 32; i++) begin
            n = n + int'(w[i]);
        end
        return n;
    endfunction

    // version word per revision
    function automatic logic [31:0] version_word(input spec_rev_t rev);
        logic [31:0] v;
        v = {`VER_MAJOR_1_3, `VER_MINOR_1_3};
        case (rev)
            REV_0_95: v = {`VER_MAJOR_0_95, `VER_MINOR_0_95};
            REV_1_0:  v = {`VER_MAJOR_1_3, `VER_MINOR_1_0};
            REV_1_1:  v = {`VER_MAJOR_1_3, `VER_MINOR_1_1};
            REV_1_2:  v = {`VER_MAJOR_1_3, `VER_MINOR_1_2};
            default:  v = {`VER_MAJOR_1_3, `VER_MINOR_1_3};
        endcase
        return v;
    endfunction

    // exact match of a bus address against a register offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // elaboration checks on the map
    if (PORTS_AVAIL == 32'h0) begin : g_map_empty
        $error("availability map must have at least one bit set");
    end
    if (ones(PORTS_AVAIL) > int'(PORT_COUNT) + 1) begin : g_map_wide
        $error("availability map has more bits than the port count allows");
    end
    if ((PORTS_AVAIL & CCC_BIT) != 32'h0) begin : g_vec_used
        $error("coalescing vector must name an unavailable port");
    end

    // ==========================================================
    // registers
    logic [31:0]          pending_bits_r;
    logic [15:0]          coalesce_timeout_r;
    logic [7:0]           completion_threshold_r;
    logic                 coalesce_on_r;
    logic [31:0]          coalesce_port_select_r;
    logic [31:0]          port_sel_active_r;
    logic                 global_irq_on_r;
    logic [15:0]          coalesce_countdown_r;
    logic [7:0]           completion_tally_r;
    logic [15:0]          timeout_live_r;
    logic [7:0]           thresh_live_r;
    coal_state_t          state_r;
    logic                 ccc_fire;
    logic                 tick;
    logic [$clog2(NPORTS):0] done_cnt;
    logic [8:0]           tally_sum;
    logic                 wr_ctl;
    logic                 wr_pend;
    logic                 wr_sel;
    logic                 wr_glb;
    logic                 sel_busy;
    logic                 cd_step;
    logic [31:0]          ev_wide;
    logic [31:0]          pend_set;
    logic [31:0]          pend_clr;

    // ==========================================================
    // helpers
    ms_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (tick)
    );

    completion_counter #(
        .NPORTS (NPORTS)
    ) u_cnt (
        .done_in (port_cmd_done),
        .select  (port_sel_active_r[NPORTS-1:0]),
        .count   (done_cnt)
    );

    // write strobes, one per writable register
    assign wr_pend   = reg_wr && hit(reg_addr, `OFS_PORT_IRQ_PENDING);
    assign wr_ctl    = reg_wr && hit(reg_addr, `OFS_COALESCE_CONTROL);
    assign wr_sel    = reg_wr && hit(reg_addr, `OFS_COALESCE_PORT_SEL);
    assign wr_glb    = reg_wr && hit(reg_addr, `OFS_GLOBAL_CONTROL);

    // completion sum and the countdown step
    assign tally_sum = {1'b0, completion_tally_r} + 9'(done_cnt);
    assign sel_busy  = (port_cmd_busy & port_sel_active_r[NPORTS-1:0]) != '0;
    assign cd_step   = tick && sel_busy;

    // ==========================================================
    // coalescing control: timeout, threshold and on bit
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            coalesce_timeout_r     <= `RST_TIMEOUT;
            completion_threshold_r <= `RST_THRESH;
            coalesce_on_r          <= 1'b0;
        end else if (wr_ctl) begin
            // zero timeout is reserved: keep previous value
            if (reg_wdata[`CTL_TIMEOUT_HI:`CTL_TIMEOUT_LO] != 16'h0) begin
                coalesce_timeout_r <= reg_wdata[`CTL_TIMEOUT_HI:`CTL_TIMEOUT_LO];
            end
            completion_threshold_r <= reg_wdata[`CTL_THRESH_HI:`CTL_THRESH_LO];
            coalesce_on_r          <= reg_wdata[`CTL_ON_BIT];
        end
    end

    // port select, only available ports can be chosen
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            coalesce_port_select_r <= `RST_PORT_SEL;
        end else if (wr_sel) begin
            coalesce_port_select_r <= reg_wdata & PORTS_AVAIL;
        end
    end

    // global interrupt on bit, cleared by reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            global_irq_on_r <= 1'b0;
        end else if (wr_glb) begin
            global_irq_on_r <= reg_wdata[`GLB_IRQ_ON_BIT];
        end
    end

    // port select takes effect on the next millisecond tick
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            port_sel_active_r <= `RST_PORT_SEL;
        end else if (tick) begin
            port_sel_active_r <= coalesce_port_select_r;
        end
    end

    // ==========================================================
    // coalescing engine: off and run states
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= ST_OFF;
        end else begin
            case (state_r)
                ST_OFF: begin
                    if (coalesce_on_r) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!coalesce_on_r) begin
                        state_r <= ST_OFF;
                    end
                end
                default: state_r <= ST_OFF;
            endcase
        end
    end

    // live settings latched on the off-to-on edge
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            timeout_live_r <= `RST_TIMEOUT;
            thresh_live_r  <= `RST_THRESH;
        end else if (state_r == ST_OFF && coalesce_on_r) begin
            timeout_live_r <= coalesce_timeout_r;
            thresh_live_r  <= completion_threshold_r;
        end
    end

    // countdown: load on start, reload on fire, step on busy ticks
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            coalesce_countdown_r <= `RST_TIMEOUT;
        end else if (state_r == ST_OFF) begin
            if (coalesce_on_r) begin
                coalesce_countdown_r <= coalesce_timeout_r;
            end
        end else if (state_r == ST_RUN && coalesce_on_r) begin
            if (ccc_fire) begin
                coalesce_countdown_r <= timeout_live_r;
            end else if (cd_step) begin
                coalesce_countdown_r <= coalesce_countdown_r - 16'h1;
            end
        end
    end

    // completion tally: cleared while off and on every fire
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            completion_tally_r <= 8'h00;
        end else if (state_r == ST_OFF) begin
            completion_tally_r <= 8'h00;
        end else if (state_r == ST_RUN && coalesce_on_r) begin
            if (ccc_fire) begin
                completion_tally_r <= 8'h00;
            end else begin
                completion_tally_r <= tally_sum[7:0];
            end
        end
    end

    // fire on countdown exhaustion or tally reaching threshold
    always_comb begin
        ccc_fire = 1'b0;
        if (state_r == ST_RUN && coalesce_on_r) begin
            if (coalesce_countdown_r == 16'h0) begin
                ccc_fire = 1'b1;
            end
            if (thresh_live_r != 8'h00 &&
                tally_sum >= {1'b0, thresh_live_r}) begin
                ccc_fire = 1'b1;
            end
        end
    end

    // ==========================================================
    // pending bitmask: set and clear vectors
    assign ev_wide  = 32'(port_irq_event);
    assign pend_set = (ev_wide & PORTS_AVAIL)
                    | (ccc_fire ? CCC_BIT : 32'h0);
    assign pend_clr = wr_pend ? reg_wdata : 32'h0;

    // one flop per position; a set wins over a clear in the same cycle
    for (genvar b = 0; b < 32; b++) begin : g_pend
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                pending_bits_r[b] <= 1'b0;
            end else if (!DEFINED_MASK[b]) begin
                pending_bits_r[b] <= 1'b0;
            end else if (pend_set[b]) begin
                pending_bits_r[b] <= 1'b1;
            end else if (pend_clr[b]) begin
                pending_bits_r[b] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // host request: global on and any defined pending bit
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            host_irq <= 1'b0;
        end else begin
            host_irq <= global_irq_on_r && (pending_bits_r != 32'h0);
        end
    end

    // coalescing pulse, gated by the global on bit
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            coalesce_irq_pulse <= 1'b0;
        end else begin
            coalesce_irq_pulse <= ccc_fire && global_irq_on_r;
        end
    end

    // message vector used for coalescing interrupts
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            msi_vector <= 5'h00;
        end else begin
            msi_vector <= CCC_VECTOR;
        end
    end

    // ==========================================================
    // read path, data one cycle after strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            if (reg_addr == `OFS_PORT_IRQ_PENDING) begin
                reg_rdata <= pending_bits_r;
            end else if (reg_addr == `OFS_PORTS_AVAILABLE_MAP) begin
                reg_rdata <= PORTS_AVAIL;
            end else if (reg_addr == `OFS_SPEC_VERSION) begin
                reg_rdata <= version_word(SPEC_REV);
            end else if (reg_addr == `OFS_COALESCE_CONTROL) begin
                reg_rdata <= {coalesce_timeout_r, completion_threshold_r,
                              CCC_VECTOR, 2'b00, coalesce_on_r};
            end else if (reg_addr == `OFS_COALESCE_PORT_SEL) begin
                reg_rdata <= coalesce_port_select_r;
            end else if (reg_addr == `OFS_GLOBAL_CONTROL) begin
                reg_rdata <= {30'h0, global_irq_on_r, 1'b0};
            end else begin
                reg_rdata <= 32'h0;
            end
        end else begin
            reg_rdata <= 32'h0;
        end
    end

endmodule

/* File: core/irq_coalesce_defines.svh */
`ifndef IRQ_COALESCE_DEFINES_SVH
`define IRQ_COALESCE_DEFINES_SVH

// ==========================================================
// register offsets
`define OFS_PORT_IRQ_PENDING    8'h08
`define OFS_PORTS_AVAILABLE_MAP 8'h0c
`define OFS_SPEC_VERSION        8'h10
`define OFS_COALESCE_CONTROL    8'h14
`define OFS_COALESCE_PORT_SEL   8'h18
`define OFS_GLOBAL_CONTROL      8'h04

// ==========================================================
// field positions
`define CTL_TIMEOUT_HI   31
`define CTL_TIMEOUT_LO   16
`define CTL_THRESH_HI    15
`define CTL_THRESH_LO    8
`define CTL_VECTOR_HI    7
`define CTL_VECTOR_LO    3
`define CTL_ON_BIT       0
`define GLB_IRQ_ON_BIT   1

// ==========================================================
// reset values and version words
`define RST_TIMEOUT      16'h0001
`define RST_THRESH       8'h01
`define RST_PORT_SEL     32'h0000_0000
`define VER_MAJOR_1_3    16'h0001
`define VER_MINOR_1_3    16'h0300
`define VER_MAJOR_0_95   16'h0000
`define VER_MINOR_0_95   16'h0905
`define VER_MINOR_1_0    16'h0000
`define VER_MINOR_1_1    16'h0100
`define VER_MINOR_1_2    16'h0200

// ==========================================================
// timing
`define CLK_FREQ_HZ      200000000
`define TICK_PERIOD_US   1000
`define TICK_CYCLES      ((`CLK_FREQ_HZ / 1000000) * `TICK_PERIOD_US)

`endif

/* File: core/irq_coalesce_pkg.sv */
package irq_coalesce_pkg;

    // version revision selection
    typedef enum logic [2:0] {
        REV_0_95 = 3'h0,
        REV_1_0  = 3'h1,
        REV_1_1  = 3'h2,
        REV_1_2  = 3'h3,
        REV_1_3  = 3'h4
    } spec_rev_t;

    // coalescing engine states
    typedef enum logic [1:0] {
        ST_OFF = 2'b01,
        ST_RUN = 2'b10
    } coal_state_t;

endpackage

/* File: core/ms_tick_gen.sv */
`timescale 1ns/100ps
`include "irq_coalesce_defines.svh"

// one-cycle enable pulse every millisecond
module ms_tick_gen #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    output logic      tick
);

    localparam int CW = $clog2(TICK_CYCLES);

    logic [CW-1:0] cnt_r;

    // free-running divider
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else if (cnt_r == CW'(TICK_CYCLES - 1)) begin
            cnt_r <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick  <= 1'b0;
        end
    end

endmodule

/* File: testbench/hba_irq_sva.sv */
`timescale 1ns/100ps
// ==========================================================
// port checker
module hba_irq_sva #(
    parameter int          NPORTS      = 32,
    parameter logic [31:0] PORTS_AVAIL = 32'h0000_000f,
    parameter logic [4:0]  CCC_VECTOR  = 5'h1f
) (
    input wire logic              clk_sys,
    input wire logic              rst_n,
    input wire logic [7:0]        reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic [NPORTS-1:0] port_irq_event,
    input wire logic [NPORTS-1:0] port_cmd_busy,
    input wire logic [NPORTS-1:0] port_cmd_done,
    input wire logic              host_irq,
    input wire logic              coalesce_irq_pulse,
    input wire logic [4:0]        msi_vector
);
    logic on_r;
    logic glb_r;
    // mirror of enable bits written by software
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            on_r  <= 1'b0;
            glb_r <= 1'b0;
        end else if (reg_wr && reg_addr == 8'h14) begin
            on_r <= reg_wdata[0];
        end else if (reg_wr && reg_addr == 8'h04) begin
            glb_r <= reg_wdata[1];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_avail; reg_rd && reg_addr == 8'h0c |=> reg_rdata == PORTS_AVAIL; endproperty
    a_avail: assert property (p_avail) else $error("map mismatch");
    property p_ver; reg_rd && reg_addr == 8'h10 |=> reg_rdata == 32'h0001_0300; endproperty
    a_ver: assert property (p_ver) else $error("version mismatch");
    property p_ctl; reg_rd && reg_addr == 8'h14 |=> reg_rdata[7:1] == {CCC_VECTOR, 2'b00};
    endproperty
    a_ctl: assert property (p_ctl) else $error("control low bits wrong");
    property p_pend; reg_rd && reg_addr == 8'h08
        |=> (reg_rdata & ~(PORTS_AVAIL | (32'h1 << CCC_VECTOR))) == 32'h0; endproperty
    a_pend: assert property (p_pend) else $error("undefined pending bit");
    property p_vec; $past(rst_n) |-> msi_vector == CCC_VECTOR; endproperty
    a_vec: assert property (p_vec) else $error("vector wrong");
    property p_coal_irq; coalesce_irq_pulse |=> host_irq; endproperty
    a_coal_irq: assert property (p_coal_irq) else $error("no request after pulse");
    property p_off; !on_r [*3] |-> !coalesce_irq_pulse; endproperty
    a_off: assert property (p_off) else $error("pulse while off");
    property p_gate; !glb_r [*3] |-> !host_irq && !coalesce_irq_pulse; endproperty
    a_gate: assert property (p_gate) else $error("request while gated");
    property p_evt; glb_r && |(port_irq_event & PORTS_AVAIL) |-> ##2 host_irq; endproperty
    a_evt: assert property (p_evt) else $error("event lost");
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
// ==========================================================
// bench for the interrupt status and coalescing block
module testbench;
    logic        clk_sys, rst_n, reg_wr, reg_rd, host_irq, coalesce_irq_pulse;
    logic        rd_d = 1'b0;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, ev, busy, done, st, r;
    logic [4:0]  msi_vector;
    logic [31:0] exp_q[$];
    int          failures, n_compared, cyc, n_pulse, last_p, gap, np, i;
    hba_irq_status_coalescing #(.TICK_CYCLES(20)) hba_irq_status_coalescing_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_irq_event(ev),
        .port_cmd_busy(busy), .port_cmd_done(done), .host_irq(host_irq),
        .coalesce_irq_pulse(coalesce_irq_pulse), .msi_vector(msi_vector));
    // clock, 5 ns period
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] xs();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask
    task automatic pulse(input logic is_done, input logic [31:0] m);
        @(posedge clk_sys);
        if (is_done) done <= m;
        else ev <= m;
        @(posedge clk_sys);
        done <= 32'h0;
        ev   <= 32'h0;
    endtask
    task automatic print_verdict();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // read data monitor, pulse timing and hang guard
    always @(posedge clk_sys) begin
        if (rd_d) chk(reg_rdata, exp_q.pop_front());
        rd_d <= reg_rd;
        cyc++;
        if (coalesce_irq_pulse) begin
            gap = cyc - last_p;
            last_p = cyc;
            n_pulse++;
        end
        if (cyc == 20000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, ev, busy, done, rst_n} = '0;
        st = 32'd50;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(8'h0c, 32'h0000_000f);
        rd(8'h10, 32'h0001_0300);
        rd(8'h14, 32'h0001_01f8);
        rd(8'h08, 32'h0);
        rd(8'h40, 32'h0);
        wr(8'h14, 32'h0003_0206);
        rd(8'h14, 32'h0003_02f8);
        wr(8'h14, 32'h0000_0400);
        rd(8'h14, 32'h0003_04f8);
        $display("register test done");
        wr(8'h04, 32'h2);
        for (i = 0; i < 4; i++) begin
            r = xs() & 32'h7fff_ffff;
            pulse(1'b0, r);
            rd(8'h08, r & 32'hf);
            #1 chk(host_irq, |(r & 32'hf));
            wr(8'h08, r);
            rd(8'h08, 32'h0);
        end
        wr(8'h04, 32'h0);
        pulse(1'b0, 32'h2);
        rd(8'h08, 32'h2);
        #1 chk(host_irq, 1'b0);
        wr(8'h04, 32'h2);
        repeat (2) @(posedge clk_sys);
        #1 chk(host_irq, 1'b1);
        wr(8'h08, 32'hffff_ffff);
        $display("pending test done");
        wr(8'h14, 32'h00ff_0301);
        wr(8'h18, 32'hffff_ffff);
        rd(8'h18, 32'hf);
        repeat (25) @(posedge clk_sys);
        np = n_pulse;
        pulse(1'b1, 32'h12);
        pulse(1'b1, 32'h12);
        repeat (3) @(posedge clk_sys);
        chk(n_pulse, np);
        pulse(1'b1, 32'h12);
        repeat (2) @(posedge clk_sys);
        chk(n_pulse, np + 1);
        rd(8'h08, 32'h8000_0000);
        wr(8'h08, 32'h8000_0000);
        $display("count test done");
        wr(8'h14, 32'h00ff_0300);
        wr(8'h14, 32'h0002_0000);
        wr(8'h14, 32'h0002_0001);
        np = n_pulse;
        for (i = 0; i < 5; i++) pulse(1'b1, 32'h1);
        repeat (100) @(posedge clk_sys);
        chk(n_pulse, np);
        busy <= 32'h1;
        for (i = 0; i < 200 && n_pulse < np + 2; i++) @(posedge clk_sys);
        chk(n_pulse, np + 2);
        chk(gap, 40);
        wr(8'h14, 32'h0002_0000);
        np = n_pulse;
        repeat (100) @(posedge clk_sys);
        chk(n_pulse, np);
        busy <= 32'h0;
        $display("timeout test done");
        print_verdict();
    end
endmodule
bind hba_irq_status_coalescing hba_irq_sva #(
    .NPORTS      (NPORTS),
    .PORTS_AVAIL (PORTS_AVAIL),
    .CCC_VECTOR  (CCC_VECTOR)
) hba_irq_sva_inst (
    .clk_sys            (clk_sys),
    .rst_n              (rst_n),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_rdata          (reg_rdata),
    .port_irq_event     (port_irq_event),
    .port_cmd_busy      (port_cmd_busy),
    .port_cmd_done      (port_cmd_done),
    .host_irq           (host_irq),
    .coalesce_irq_pulse (coalesce_irq_pulse),
    .msi_vector         (msi_vector)
);
